// ==== bench/lpmc_far_side.sv ====
// behavioural processor core and wake-up sources facing the controller
`timescale 1ns/10ps
module lpmc_far_side (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        sleep_go,
    input  wire logic        src_go,
    input  wire logic [4:0]  src_sel,
    input  wire logic        core_clk_en,
    input  wire logic        core_reset,
    output logic             core_sleep_req,
    output logic             periph_irq,
    output logic [15:0]      external_event_lines,
    output logic             supply_level_detector,
    output logic             rtc_alarm,
    output logic             wakeup_pin,
    output logic             external_reset_pin_n,
    output logic             independent_watchdog_rst
);
    logic        pend_reg;   // sleep asked, not yet taken
    logic [21:0] pulse_reg;  // one bit per source
    logic [1:0]  hold_reg;   // cycles left of a pulse
    // request stays up until the core clock stops
    always_ff @(posedge core_clk) begin
        if (rst || !core_clk_en) begin
            pend_reg <= 1'b0;
        end else if (sleep_go) begin
            pend_reg <= 1'b1;
        end
    end
    // drop the request the moment the clock returns, else the core would doze again
    assign core_sleep_req = pend_reg | (~core_clk_en & ~core_reset);
    // four-cycle pulses, long enough for the edge detectors
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pulse_reg <= '0;
            hold_reg  <= 2'h0;
        end else if (src_go) begin
            pulse_reg <= 22'h1 << src_sel;
            hold_reg  <= 2'h3;
        end else if (hold_reg != 2'h0) begin
            hold_reg <= hold_reg - 2'h1;
        end else begin
            pulse_reg <= '0;
        end
    end
    assign external_event_lines     = pulse_reg[15:0];
    assign supply_level_detector    = pulse_reg[16];
    assign rtc_alarm                = pulse_reg[17];
    assign wakeup_pin               = pulse_reg[18];
    assign independent_watchdog_rst = pulse_reg[19];
    assign external_reset_pin_n     = ~pulse_reg[20];   // pulled up when idle
    assign periph_irq               = pulse_reg[21];
endmodule : lpmc_far_side

// ==== bench/tb.sv ====
// self-checking testbench of the low-power mode controller
`timescale 1ns/10ps
`include "lpmc_defs.svh"
module tb;
    import lpmc_pkg::*;
    logic        core_clk, rst, hwrite, hsel, sleep_go, src_go;  // bench drives
    logic [31:0] haddr, hwdata, hrdata, rd;                      // bus words
    logic [1:0]  htrans;                                         // transfer kind
    logic [2:0]  hsize;                                          // always a word
    logic [4:0]  src_sel;                                        // wake source
    logic        hreadyout, hresp, core_sleep_req, periph_irq;   // design side
    logic [15:0] ext_lines;                                      // event pins
    logic        sld, alarm, wpin, rpin_n, wdg_rst;              // wake lines
    lpmc_reg_mode_type reg_mode;                                 // regulator
    logic        reg_enable, core_clk_en, domain_clk_en, pll_en; // enables
    logic        ifo_en, efo_en, core_domain_power, aon_en;      // supplies
    logic        sld_en, core_reset, irq;                        // misc outputs
    int          failures, samples_checked;                      // tallies
    int          srcs[4] = '{17, 18, 19, 20};                    // standby causes
    // expected output groups: mode, reg_en, clocks, plls, oscs, power, aon, reset
    localparam logic [10:0] RUN   = 11'b00_111111110;
    localparam logic [10:0] SLEEP = 11'b00_101111110;
    localparam logic [10:0] STOPM = 11'b00_100000110;
    localparam logic [10:0] STOPL = 11'b01_100000110;
    localparam logic [10:0] STBY  = 11'b10_000000011;
    lpmc_top dut (.core_clk(core_clk), .rst(rst), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hsel(hsel), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .core_sleep_req(core_sleep_req), .periph_irq(periph_irq),
        .external_event_lines(ext_lines), .supply_level_detector(sld), .rtc_alarm(alarm),
        .wakeup_pin(wpin), .external_reset_pin_n(rpin_n), .independent_watchdog_rst(wdg_rst),
        .reg_mode(reg_mode), .reg_enable(reg_enable), .core_clk_en(core_clk_en),
        .domain_clk_en(domain_clk_en), .pll_en(pll_en), .internal_fast_oscillator_en(ifo_en),
        .external_fast_oscillator_en(efo_en), .core_domain_power(core_domain_power),
        .always_on_clk_en(aon_en), .supply_level_detector_en(sld_en),
        .core_reset(core_reset), .irq(irq));
    lpmc_far_side far (.core_clk(core_clk), .rst(rst), .sleep_go(sleep_go), .src_go(src_go),
        .src_sel(src_sel), .core_clk_en(core_clk_en), .core_reset(core_reset),
        .core_sleep_req(core_sleep_req), .periph_irq(periph_irq),
        .external_event_lines(ext_lines), .supply_level_detector(sld), .rtc_alarm(alarm),
        .wakeup_pin(wpin), .external_reset_pin_n(rpin_n), .independent_watchdog_rst(wdg_rst));
    // 100 ns clock
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // power-related outputs packed in one word for compact compares
    function automatic logic [10:0] outs();
        return {reg_mode, reg_enable, core_clk_en, domain_clk_en, pll_en, ifo_en, efo_en,
                core_domain_power, aon_en, core_reset};
    endfunction : outs
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one single ahb transfer; read data lands in rd
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= a;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    // fire one wake source
    task automatic fire(input int s);
        @(posedge core_clk);
        src_sel <= s[4:0];
        src_go  <= 1'b1;
        @(posedge core_clk);
        src_go  <= 1'b0;
    endtask : fire
    // core asks for low power, then the mode settles
    task automatic doze();
        @(posedge core_clk);
        sleep_go <= 1'b1;
        @(posedge core_clk);
        sleep_go <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
    endtask : doze
    // bounded wait until the core runs again out of reset
    task automatic wait_run();
        int n;
        n = 0;
        while ((core_clk_en !== 1'b1 || core_reset !== 1'b0) && n < 60) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk(outs(), RUN);
    endtask : wait_run
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    // watchdog on the whole run
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        wrap_up();
    end
    // main sequence
    initial begin
        {hwrite, hsel, sleep_go, src_go, haddr, hwdata, htrans, src_sel} = '0;
        hsize = 3'h2;
        rst   = 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(outs(), RUN);
        bus(0, `LPMC_ADDR_CTRL, 0);
        chk(rd, 0);
        chk(hresp, 0);      // slave always answers okay
        chk(hreadyout, 1);  // zero wait states
        bus(0, `LPMC_ADDR_STATUS, 0);
        chk(rd, 0);
        bus(0, `LPMC_ADDR_EVEN, 0);
        chk(rd, `LPMC_EVEN_RESET);
        bus(1, 32'h40, 32'hffff_ffff);
        bus(0, 32'h40, 0);
        chk(rd, 0);
        bus(1, `LPMC_ADDR_MASK, 0);
        // sleep: only the core halts, a peripheral interrupt wakes it
        doze();
        chk(outs(), SLEEP);
        fire(21);
        wait_run();
        // stop: disabled line ignored, enabled lines wake, regulator per setting
        bus(1, `LPMC_ADDR_EVEN, 32'h3ffdf);
        for (int i = 0; i < 4; i++) begin
            bus(1, `LPMC_ADDR_CTRL, 32'h2 | ((i % 2) << 3));
            doze();
            chk(outs(), (i % 2) ? STOPL : STOPM);
            if (i == 0) begin
                fire(5);
                repeat (6) @(posedge core_clk);
                #1;
                chk(core_clk_en, 0);
            end
            fire(i == 0 ? 0 : 14 + i);
            wait_run();
            bus(0, `LPMC_ADDR_CTRL, 0);
            chk(rd, 32'h2 | ((i % 2) << 3));
        end
        // stop exit flag, masked then unmasked then cleared
        bus(0, `LPMC_ADDR_IRQ, 0);
        chk(rd & 32'h8, 32'h8);
        chk(irq, 0);
        bus(1, `LPMC_ADDR_MASK, 32'h8);
        repeat (2) @(posedge core_clk);
        chk(irq, 1);
        bus(1, `LPMC_ADDR_IRQ, 32'h8);
        repeat (2) @(posedge core_clk);
        chk(irq, 0);
        // software enables the detector, a crossing interrupts
        bus(1, `LPMC_ADDR_CTRL, 32'h10);
        #1;
        chk(sld_en, 1);
        bus(1, `LPMC_ADDR_MASK, 32'h2);
        fire(16);
        repeat (4) @(posedge core_clk);
        #1;
        chk(irq, 1);
        // standby: power off, each cause restarts through reset
        for (int i = 0; i < 4; i++) begin
            bus(1, `LPMC_ADDR_CTRL, 32'h4);
            doze();
            chk(outs(), STBY);
            fire(srcs[i]);
            wait_run();
            bus(0, `LPMC_ADDR_CTRL, 0);
            chk(rd, 0);
            bus(0, `LPMC_ADDR_WAKE, 0);
            chk(rd & (32'h8 >> i), 32'h8 >> i);
        end
        // sleep-wake and standby-exit flags stay sticky
        bus(0, `LPMC_ADDR_IRQ, 0);
        chk(rd & 32'h5, 32'h5);
        wrap_up();
    end
endmodule : tb

// ==== design/lpmc_defs.svh ====
// constants for the low-power mode controller
`ifndef LPMC_DEFS_SVH
`define LPMC_DEFS_SVH
`define LPMC_ADDR_CTRL    12'h000
`define LPMC_ADDR_STATUS  12'h004
`define LPMC_ADDR_IRQ     12'h008
`define LPMC_ADDR_MASK    12'h00c
`define LPMC_ADDR_EVEN    12'h010
`define LPMC_ADDR_WAKE    12'h014
`define LPMC_ADDR_MSB     11
`define LPMC_CTRL_SLEEP   0
`define LPMC_CTRL_STOP    1
`define LPMC_CTRL_STBY    2
`define LPMC_CTRL_LPREG   3
`define LPMC_CTRL_SLDEN   4
`define LPMC_IRQ_WIDTH    4
`define LPMC_IRQ_WAKE     0
`define LPMC_IRQ_SLD      1
`define LPMC_IRQ_STBYOUT  2
`define LPMC_IRQ_STOPOUT  3
`define LPMC_RESET_CYC    4'h8
`define LPMC_EVEN_RESET   18'h3ffff
`define LPMC_CAUSE_WIDTH  4
`define LPMC_CAUSE_PIN    0
`define LPMC_CAUSE_WDG    1
`define LPMC_CAUSE_WPIN   2
`define LPMC_CAUSE_RTC    3
`endif

// ==== design/lpmc_pkg.sv ====
// types for the low-power mode controller
package lpmc_pkg;
    typedef enum logic [1:0] {
        LPMC_REG_MAIN,
        LPMC_REG_LOWPWR,
        LPMC_REG_OFF
    } lpmc_reg_mode_type;
    typedef enum logic [2:0] {
        LPMC_RUN,
        LPMC_SLEEP,
        LPMC_STOP,
        LPMC_STANDBY,
        LPMC_RESTART
    } lpmc_state_type;
endpackage : lpmc_pkg

// ==== design/lpmc_top.sv ====
// low-power mode controller with ahb-lite register slave
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
`include "lpmc_defs.svh"
module lpmc_top #(
    parameter int NUM_EXT = 16
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic                   hsel,
    input  wire logic                   hready,
    input  wire logic [31:0]            hwdata,
    output logic      [31:0]            hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    input  wire logic                   core_sleep_req,
    input  wire logic                   periph_irq,
    input  wire logic [NUM_EXT-1:0]     external_event_lines,
    input  wire logic                   supply_level_detector,
    input  wire logic                   rtc_alarm,
    input  wire logic                   wakeup_pin,
    input  wire logic                   external_reset_pin_n,
    input  wire logic                   independent_watchdog_rst,
    output lpmc_pkg::lpmc_reg_mode_type reg_mode,
    output logic                        reg_enable,
    output logic                        core_clk_en,
    output logic                        domain_clk_en,
    output logic                        pll_en,
    output logic                        internal_fast_oscillator_en,
    output logic                        external_fast_oscillator_en,
    output logic                        core_domain_power,
    output logic                        always_on_clk_en,
    output logic                        supply_level_detector_en,
    output logic                        core_reset,
    output logic                        irq
);
    import lpmc_pkg::*;

    localparam int EV_W = NUM_EXT + 2;  // sixteen pins plus detector and alarm

    initial begin
        if (NUM_EXT != 16) $error("lpmc_top: NUM_EXT must be 16");
    end

    // bus data-phase capture
    logic        dp_wr_reg, dp_wr_next;       // pending write
    logic [11:0] dp_addr_reg, dp_addr_next;   // captured offset
    logic [31:0] rdata_reg, rdata_next;       // read data
    // software registers
    logic [4:0]  ctrl_reg, ctrl_next;         // mode requests and options
    logic [3:0]  irq_st_reg, irq_st_next;     // sticky events
    logic [3:0]  mask_reg, mask_next;         // interrupt mask
    logic [EV_W-1:0] even_reg, even_next;     // event line enables
    logic [3:0]  cause_reg, cause_next;       // last standby exit cause
    // mode machine
    lpmc_state_type state_reg, state_next;
    logic [3:0]  rcnt_reg, rcnt_next;         // restart hold counter
    logic        irq_reg, irq_next;
    logic        sld_prev_reg, sld_prev_next;
    logic        wk_prev_reg, wk_prev_next;
    logic        ev_hit;                      // event-line rising edge

    wire addr_ph = hsel & hready & htrans[1];
    wire [EV_W-1:0] ev_vec = {rtc_alarm, supply_level_detector, external_event_lines};

    // the event lines share one edge detector
    lpmc_wake_detect #(.WIDTH(EV_W)) u_ev (
        .core_clk (core_clk),
        .rst      (rst),
        .level_in (ev_vec),
        .enable   (even_reg),
        .hit      (ev_hit)
    );

    // bus slave: zero wait states, writes land in the data phase
    always_comb begin
        dp_wr_next   = addr_ph & hwrite;
        dp_addr_next = addr_ph ? haddr[`LPMC_ADDR_MSB:0] : dp_addr_reg;
        rdata_next   = '0;
        if (addr_ph && !hwrite) begin
            unique case (haddr[`LPMC_ADDR_MSB:0])
                `LPMC_ADDR_CTRL:   rdata_next = {27'h0, ctrl_reg};
                `LPMC_ADDR_STATUS: rdata_next = {29'h0, state_reg};
                `LPMC_ADDR_IRQ:    rdata_next = {28'h0, irq_st_reg};
                `LPMC_ADDR_MASK:   rdata_next = {28'h0, mask_reg};
                `LPMC_ADDR_EVEN:   rdata_next = {14'h0, even_reg};
                `LPMC_ADDR_WAKE:   rdata_next = {28'h0, cause_reg};
                default:           rdata_next = '0;  // unmapped reads zero
            endcase
        end
    end

    // mode machine and register updates
    always_comb begin
        logic [3:0] ev_set;
        logic       stby_exit;
        logic [3:0] cause_now;
        ev_set        = '0;
        ctrl_next     = ctrl_reg;
        mask_next     = mask_reg;
        even_next     = even_reg;
        cause_next    = cause_reg;
        state_next    = state_reg;
        rcnt_next     = rcnt_reg;
        sld_prev_next = supply_level_detector;
        wk_prev_next  = wakeup_pin;
        cause_now     = '0;
        cause_now[`LPMC_CAUSE_PIN]  = ~external_reset_pin_n;
        cause_now[`LPMC_CAUSE_WDG]  = independent_watchdog_rst;
        cause_now[`LPMC_CAUSE_WPIN] = wakeup_pin & ~wk_prev_reg;
        cause_now[`LPMC_CAUSE_RTC]  = rtc_alarm;
        stby_exit     = |cause_now;
        // detector crossing only reported when enabled
        ev_set[`LPMC_IRQ_SLD] = ctrl_reg[`LPMC_CTRL_SLDEN] &
                                (supply_level_detector ^ sld_prev_reg);
        if (dp_wr_reg) begin
            unique case (dp_addr_reg)
                `LPMC_ADDR_CTRL: ctrl_next = hwdata[4:0];
                `LPMC_ADDR_MASK: mask_next = hwdata[3:0];
                `LPMC_ADDR_EVEN: even_next = hwdata[EV_W-1:0];
                default: ;
            endcase
        end
        unique case (state_reg)
            LPMC_RUN: begin
                if (ctrl_reg[`LPMC_CTRL_STBY] && core_sleep_req)
                    state_next = LPMC_STANDBY;
                else if (ctrl_reg[`LPMC_CTRL_STOP] && core_sleep_req)
                    state_next = LPMC_STOP;
                else if (core_sleep_req)
                    state_next = LPMC_SLEEP;
            end
            LPMC_SLEEP: begin
                if (periph_irq || ev_hit) begin
                    state_next = LPMC_RUN;
                    ev_set[`LPMC_IRQ_WAKE] = 1'b1;
                end
            end
            LPMC_STOP: begin
                if (ev_hit) begin
                    state_next = LPMC_RUN;
                    ev_set[`LPMC_IRQ_STOPOUT] = 1'b1;
                end
            end
            LPMC_STANDBY: begin
                if (stby_exit) begin
                    state_next = LPMC_RESTART;
                    rcnt_next  = `LPMC_RESET_CYC;
                    cause_next = cause_now;
                    ctrl_next  = '0;  // core-domain state lost
                end
            end
            LPMC_RESTART: begin
                rcnt_next = rcnt_reg - 4'h1;
                if (rcnt_reg == 4'h1) begin
                    state_next = LPMC_RUN;
                    ev_set[`LPMC_IRQ_STBYOUT] = 1'b1;
                end
            end
            default: state_next = LPMC_RUN;
        endcase
        // set wins over write-one-to-clear
        irq_st_next = irq_st_reg;
        if (dp_wr_reg && dp_addr_reg == `LPMC_ADDR_IRQ)
            irq_st_next = irq_st_reg & ~hwdata[3:0];
        irq_st_next = irq_st_next | ev_set;
        irq_next    = |(irq_st_next & mask_next);
    end

    // bus, register and mode-machine state registered here; output flops below
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dp_wr_reg    <= 1'b0;
            dp_addr_reg  <= '0;
            rdata_reg    <= '0;
            ctrl_reg     <= '0;
            irq_st_reg   <= '0;
            mask_reg     <= '0;
            even_reg     <= `LPMC_EVEN_RESET;
            cause_reg    <= '0;
            state_reg    <= LPMC_RUN;   // regulator enabled on reset
            rcnt_reg     <= '0;
            irq_reg      <= 1'b0;
            sld_prev_reg <= 1'b0;
            wk_prev_reg  <= 1'b0;
        end else begin
            dp_wr_reg    <= dp_wr_next;
            dp_addr_reg  <= dp_addr_next;
            rdata_reg    <= rdata_next;
            ctrl_reg     <= ctrl_next;
            irq_st_reg   <= irq_st_next;
            mask_reg     <= mask_next;
            even_reg     <= even_next;
            cause_reg    <= cause_next;
            state_reg    <= state_next;
            rcnt_reg     <= rcnt_next;
            irq_reg      <= irq_next;
            sld_prev_reg <= sld_prev_next;
            wk_prev_reg  <= wk_prev_next;
        end
    end

    // output flops decoded from next state
    // bit 6 is the regulator enable, kept as a flop so the pin is glitch free
    lpmc_reg_mode_type rmode_reg, rmode_next;
    logic [7:0] out_reg, out_next;
    always_comb begin
        rmode_next = LPMC_REG_MAIN;
        out_next   = 8'hff;
        unique case (state_next)
            LPMC_RUN, LPMC_SLEEP: begin
                out_next[0] = (state_next == LPMC_RUN);  // core clock
                out_next[7] = 1'b0;
            end
            LPMC_STOP: begin
                rmode_next = ctrl_next[`LPMC_CTRL_LPREG] ? LPMC_REG_LOWPWR : LPMC_REG_MAIN;
                out_next   = 8'h60;  // power and regulator stay, state kept
            end
            LPMC_STANDBY: begin
                rmode_next = LPMC_REG_OFF;
                out_next   = 8'h80;  // power off, core held in reset
            end
            LPMC_RESTART: begin
                out_next = 8'hfe;  // reset asserted, core clock off
            end
            default: ;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rmode_reg <= LPMC_REG_MAIN;
            out_reg   <= 8'h7f;
        end else begin
            rmode_reg <= rmode_next;
            out_reg   <= out_next;
        end
    end

    assign reg_mode                    = rmode_reg;
    assign reg_enable                  = out_reg[6];
    assign core_clk_en                 = out_reg[0];
    assign domain_clk_en               = out_reg[1];
    assign pll_en                      = out_reg[2];
    assign internal_fast_oscillator_en = out_reg[3];
    assign external_fast_oscillator_en = out_reg[4];
    assign core_domain_power           = out_reg[5];
    assign always_on_clk_en            = 1'b1;
    assign supply_level_detector_en    = ctrl_reg[`LPMC_CTRL_SLDEN];
    assign core_reset                  = out_reg[7];
    assign irq                         = irq_reg;
    assign hrdata                      = rdata_reg;
    assign hreadyout                   = 1'b1;
    assign hresp                       = 1'b0;

    // checks
    property p_stop_clk;
        @(posedge core_clk) disable iff (rst)
        (state_reg == LPMC_STOP) |-> (!domain_clk_en && !pll_en && core_domain_power);
    endproperty
    a_stop_clk: assert property (p_stop_clk) else $error("stop clocks wrong");
    property p_stby_off;
        @(posedge core_clk) disable iff (rst)
        (state_reg == LPMC_STANDBY) |-> (!core_domain_power && reg_mode == LPMC_REG_OFF);
    endproperty
    a_stby_off: assert property (p_stby_off) else $error("standby power wrong");
    property p_restart_len;
        @(posedge core_clk) disable iff (rst)
        $rose(state_reg == LPMC_RESTART) |-> (state_reg == LPMC_RESTART)[*8] ##1
            (state_reg == LPMC_RUN);
    endproperty
    a_restart_len: assert property (p_restart_len) else $error("restart length wrong");
    property p_sleep_core;
        @(posedge core_clk) disable iff (rst)
        (state_reg == LPMC_SLEEP) |-> (!core_clk_en && domain_clk_en);
    endproperty
    a_sleep_core: assert property (p_sleep_core) else $error("sleep gating wrong");
    property p_stop_wake;
        @(posedge core_clk) disable iff (rst)
        (state_reg == LPMC_STOP && ev_hit) |=> (state_reg == LPMC_RUN);
    endproperty
    a_stop_wake: assert property (p_stop_wake) else $error("stop wake missed");
    property p_lpreg;
        @(posedge core_clk) disable iff (rst)
        (state_reg == LPMC_STOP) |-> (reg_mode == (ctrl_reg[`LPMC_CTRL_LPREG] ?
            LPMC_REG_LOWPWR : LPMC_REG_MAIN));
    endproperty
    a_lpreg: assert property (p_lpreg) else $error("stop regulator wrong");
    property p_run_main;
        @(posedge core_clk) disable iff (rst)
        (state_reg == LPMC_RUN) |-> (reg_mode == LPMC_REG_MAIN && reg_enable);
    endproperty
    a_run_main: assert property (p_run_main) else $error("run regulator wrong");
    property p_stby_exit;
        @(posedge core_clk) disable iff (rst)
        (state_reg == LPMC_STANDBY && independent_watchdog_rst) |=> (state_reg == LPMC_RESTART);
    endproperty
    a_stby_exit: assert property (p_stby_exit) else $error("standby exit missed");
    property p_irq;
        @(posedge core_clk) disable iff (rst)
        ##1 (irq == |(irq_st_reg & mask_reg));
    endproperty
    a_irq: assert property (p_irq) else $error("irq level wrong");
    c_sleep: cover property (@(posedge core_clk) state_reg == LPMC_SLEEP ##1 state_reg == LPMC_RUN);
    c_stop: cover property (@(posedge core_clk) state_reg == LPMC_STOP ##1 state_reg == LPMC_RUN);
    c_stby: cover property (@(posedge core_clk) state_reg == LPMC_STANDBY ##1
        state_reg == LPMC_RESTART);
endmodule : lpmc_top

// ==== design/lpmc_wake_detect.sv ====
// edge detector and reduction for wake-up sources
`timescale 1ns/10ps
module lpmc_wake_detect #(
    parameter int WIDTH = 18
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] level_in,
    input  wire logic [WIDTH-1:0] enable,
    output logic                  hit
);
    logic [WIDTH-1:0] prev_reg;  // last sample
    logic [WIDTH-1:0] prev_next;
    logic             hit_reg;   // registered wake flag
    logic             hit_next;

    initial begin
        if (WIDTH < 1) $error("lpmc_wake_detect: WIDTH must be positive");
    end

    // rising edge on any enabled line
    always_comb begin
        prev_next = level_in;
        hit_next  = |(level_in & ~prev_reg & enable);
    end

    // register the samples
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prev_reg <= '0;
            hit_reg  <= 1'b0;
        end else begin
            prev_reg <= prev_next;
            hit_reg  <= hit_next;
        end
    end

    assign hit = hit_reg;
endmodule : lpmc_wake_detect
